// file: rtl/stdb_pkg.sv
package stdb_pkg;

    localparam int          STDB_LINES       = 4;
    localparam int          STDB_FRAME_BITS  = 5;
    localparam int          STDB_TIME_BITS   = 16;
    localparam int          STDB_CNT_BITS    = 24;

    // Register byte offsets
    localparam logic [7:0]  STDB_OFS_LINE_CTRL   = 8'h00;
    localparam logic [7:0]  STDB_OFS_FLASH_DELAY = 8'h04;
    localparam logic [7:0]  STDB_OFS_FLASH_LEN   = 8'h08;
    localparam logic [7:0]  STDB_OFS_PAT_PERIOD  = 8'h0c;
    localparam logic [7:0]  STDB_OFS_PAT_MASK    = 8'h10;
    localparam logic [7:0]  STDB_OFS_STATUS      = 8'h14;
    localparam logic [7:0]  STDB_OFS_FILTER_BASE = 8'h20;

    // Per-line control byte in LINE_CTRL, line i at bits [8*i +: 8]
    localparam int          STDB_CTL_STRIDE   = 8;
    localparam int          STDB_CTL_DIR      = 0;
    localparam int          STDB_CTL_FLIP     = 1;
    localparam int          STDB_CTL_FLASH_ON = 2;
    localparam int          STDB_CTL_FILT_EN  = 3;

    // Status field positions
    localparam int          STDB_ST_LEVEL  = 0;
    localparam int          STDB_ST_FILT   = 4;
    localparam int          STDB_ST_FLASH  = 8;
    localparam int          STDB_ST_FRAME  = 16;

    // Reset values
    localparam logic [31:0] STDB_RST_LINE_CTRL  = 32'h0000_0000;
    localparam logic [15:0] STDB_RST_TIME       = 16'h0000;
    localparam logic [4:0]  STDB_RST_PAT_PERIOD = 5'h00;
    localparam logic [31:0] STDB_RST_PAT_MASK   = 32'hffff_ffff;

    // Timing
    localparam int          STDB_CLK_MHZ        = 125;
    localparam int          STDB_US_NS          = 1000;
    localparam int          STDB_CLK_NS         = 8;
    localparam logic [7:0]  STDB_CYC_PER_US     = 8'(STDB_US_NS / STDB_CLK_NS);
    localparam logic [23:0] STDB_DEFAULT_FILTER = 24'h00_0010;

    // Line direction values
    localparam logic        STDB_DIR_INPUT  = 1'b0;
    localparam logic        STDB_DIR_OUTPUT = 1'b1;

    typedef enum logic [1:0] {
        STDB_FL_IDLE  = 2'b00,
        STDB_FL_DELAY = 2'b01,
        STDB_FL_PULSE = 2'b10
    } stdb_flash_t;

endpackage

// file: rtl/stdb_strobe_debounce.sv
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

// Contract
// - Strobe starts after programmed offset from exposure start or accepted trigger.
// - With default pattern, an output strobe line pulses on every exposure start; code does so only with trigger_mode_ext low and the strobe engine idle.
// - Strobe length programmable; zero length means strobe follows exposure active.
// - All output lines with strobe enabled pulse together from one event.
// - Frame pattern selects strobed frames: every Nth, N of T, chosen frames.
// - Debouncer off: trigger pulses shorter than 16 clocks are ignored.
// - Debouncer on with value: pulses shorter than programmed interval are dropped.
// - Filtering applies only to lines set to input direction, value 0.
// - Filter behaves the same in every trigger mode.
// - Debounce time adds latency before an accepted trigger acts.
// - Debounce interval per line is programmed in microseconds.
// - Per-line polarity flip inverts the line input or output.
module stdb_strobe_debounce
(
    // Clock and reset
    input  wire logic                               hclk,
    input  wire logic                               hresetn,
    // AHB-Lite slave
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic [2:0]                         hsize,
    input  wire logic [31:0]                        hwdata,
    input  wire logic                               hready,
    output logic                                    hreadyout,
    output logic [31:0]                             hrdata,
    output logic                                    hresp,
    // Sensor timing
    input  wire logic                               exposure_start,
    input  wire logic                               exposure_active,
    input  wire logic                               trigger_mode_ext,
    // Accepted triggers
    output logic [stdb_pkg::STDB_LINES-1:0]         trig_fire,
    // Line pins
    input  wire logic [stdb_pkg::STDB_LINES-1:0]    line_in,
    output logic [stdb_pkg::STDB_LINES-1:0]         line_out,
    output logic [stdb_pkg::STDB_LINES-1:0]         line_oe
);
    import stdb_pkg::*;

    // Register state
    logic [31:0]                    line_ctrl_q;
    logic [STDB_TIME_BITS-1:0]      flash_delay_q;
    logic [STDB_TIME_BITS-1:0]      flash_pulse_length_q;
    logic [STDB_FRAME_BITS-1:0]     pat_period_q;
    logic [31:0]                    pat_mask_q;
    logic [STDB_TIME_BITS-1:0]      input_filter_interval_q [STDB_LINES];

    // Bus pipeline
    logic                           wr_pend_q;
    logic [7:0]                     wr_addr_q;
    logic [31:0]                    rdata_d;

    // Line datapath
    logic [STDB_LINES-1:0]          sync1_q;
    logic [STDB_LINES-1:0]          sync2_q;
    logic [STDB_LINES-1:0]          level;
    logic [STDB_LINES-1:0]          filt_q;
    logic [STDB_CNT_BITS-1:0]       filt_cnt_q [STDB_LINES];
    logic [STDB_LINES-1:0]          fire_q;
    logic [STDB_LINES-1:0]          line_out_q;
    logic [STDB_LINES-1:0]          line_oe_q;

    // Strobe engine
    stdb_flash_t                    fl_state_q;
    logic [STDB_FRAME_BITS-1:0]     frame_q;
    logic [7:0]                     us_div_q;
    logic [STDB_TIME_BITS-1:0]      us_cnt_q;
    logic                           flash_q;
    logic                           frame_event;
    logic                           frame_sel;
    logic                           us_tick;

    function automatic logic line_bit(input logic [31:0] ctrl, input int line, input int field);
        line_bit = ctrl[line * STDB_CTL_STRIDE + field];
    endfunction

    // Interval in us to cycles; disabled or zero falls back to the fixed floor
    function automatic logic [STDB_CNT_BITS-1:0] filt_limit(input logic en,
                                                           input logic [STDB_TIME_BITS-1:0] us);
        logic [STDB_CNT_BITS-1:0] cyc;
        cyc = STDB_CNT_BITS'(us) * STDB_CNT_BITS'(STDB_CYC_PER_US);
        if (en && (us != '0))
        begin
            filt_limit = cyc;
        end
        else
        begin
            filt_limit = STDB_DEFAULT_FILTER;
        end
    endfunction

    // Zero-wait slave: never stalls, never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        unique case (haddr[7:0])
            STDB_OFS_LINE_CTRL:   rdata_d = line_ctrl_q;
            STDB_OFS_FLASH_DELAY: rdata_d = {16'h0000, flash_delay_q};
            STDB_OFS_FLASH_LEN:   rdata_d = {16'h0000, flash_pulse_length_q};
            STDB_OFS_PAT_PERIOD:  rdata_d = {27'h000_0000, pat_period_q};
            STDB_OFS_PAT_MASK:    rdata_d = pat_mask_q;
            STDB_OFS_STATUS:
            begin
                rdata_d[STDB_ST_LEVEL +: STDB_LINES] = level;
                rdata_d[STDB_ST_FILT +: STDB_LINES]  = filt_q;
                rdata_d[STDB_ST_FLASH +: STDB_LINES] = line_out_q & line_oe_q;
                rdata_d[STDB_ST_FRAME +: STDB_FRAME_BITS] = frame_q;
            end
            default:
            begin
                for (int i = 0; i < STDB_LINES; i++)
                begin
                    if (haddr[7:0] == STDB_OFS_FILTER_BASE + 8'(4 * i))
                    begin
                        rdata_d = {16'h0000, input_filter_interval_q[i]};
                    end
                end
            end
        endcase
    end

    // Read data captured in the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            hrdata <= rdata_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_ctrl_q          <= STDB_RST_LINE_CTRL;
            flash_delay_q        <= STDB_RST_TIME;
            flash_pulse_length_q <= STDB_RST_TIME;
            pat_period_q         <= STDB_RST_PAT_PERIOD;
            pat_mask_q           <= STDB_RST_PAT_MASK;
            for (int i = 0; i < STDB_LINES; i++)
            begin
                input_filter_interval_q[i] <= STDB_RST_TIME;
            end
        end
        else if (wr_pend_q)
        begin
            unique case (wr_addr_q)
                STDB_OFS_LINE_CTRL:   line_ctrl_q          <= hwdata;
                STDB_OFS_FLASH_DELAY: flash_delay_q        <= hwdata[15:0];
                STDB_OFS_FLASH_LEN:   flash_pulse_length_q <= hwdata[15:0];
                STDB_OFS_PAT_PERIOD:  pat_period_q         <= hwdata[4:0];
                STDB_OFS_PAT_MASK:    pat_mask_q           <= hwdata;
                default:
                begin
                    for (int i = 0; i < STDB_LINES; i++)
                    begin
                        if (wr_addr_q == STDB_OFS_FILTER_BASE + 8'(4 * i))
                        begin
                            input_filter_interval_q[i] <= hwdata[15:0];
                        end
                    end
                end
            endcase
        end
    end

    // Pins are asynchronous: two flops before any use
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
        end
    end

    always_comb
    begin
        for (int i = 0; i < STDB_LINES; i++)
        begin
            level[i] = sync2_q[i] ^ line_bit(line_ctrl_q, i, STDB_CTL_FLIP);
        end
    end

    // Filter ignores trigger mode entirely; latency equals the threshold
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            filt_q <= '0;
            fire_q <= '0;
            for (int i = 0; i < STDB_LINES; i++)
            begin
                filt_cnt_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < STDB_LINES; i++)
            begin
                fire_q[i] <= 1'b0;
                if (line_bit(line_ctrl_q, i, STDB_CTL_DIR) != STDB_DIR_INPUT)
                begin
                    filt_q[i]     <= 1'b0;
                    filt_cnt_q[i] <= '0;
                end
                else if (level[i] == filt_q[i])
                begin
                    filt_cnt_q[i] <= '0;
                end
                else if (filt_cnt_q[i] + 1'b1 >= filt_limit(
                             line_bit(line_ctrl_q, i, STDB_CTL_FILT_EN),
                             input_filter_interval_q[i]))
                begin
                    filt_q[i]     <= level[i];
                    fire_q[i]     <= level[i];
                    filt_cnt_q[i] <= '0;
                end
                else
                begin
                    filt_cnt_q[i] <= filt_cnt_q[i] + 1'b1;
                end
            end
        end
    end

    assign trig_fire = fire_q;

    assign frame_event = trigger_mode_ext ? (|fire_q) : exposure_start;
    assign frame_sel   = pat_mask_q[frame_q];
    assign us_tick     = (us_div_q == STDB_CYC_PER_US - 8'h01);

    // Period 0 or 1 both mean every frame, matching the reset default
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frame_q <= '0;
        end
        else if (frame_event)
        begin
            if (frame_q + 1'b1 >= pat_period_q)
            begin
                frame_q <= '0;
            end
            else
            begin
                frame_q <= frame_q + 1'b1;
            end
        end
    end

    // Events during an active strobe are counted as frames but not flashed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fl_state_q <= STDB_FL_IDLE;
            us_div_q   <= 8'h00;
            us_cnt_q   <= '0;
            flash_q    <= 1'b0;
        end
        else
        begin
            us_div_q <= us_tick ? 8'h00 : us_div_q + 8'h01;
            if (us_tick)
            begin
                us_cnt_q <= us_cnt_q + 1'b1;
            end
            unique case (fl_state_q)
                STDB_FL_IDLE:
                begin
                    if (frame_event && frame_sel)
                    begin
                        us_div_q <= 8'h00;
                        us_cnt_q <= '0;
                        if (flash_delay_q == '0)
                        begin
                            fl_state_q <= STDB_FL_PULSE;
                            flash_q    <= 1'b1;
                        end
                        else
                        begin
                            fl_state_q <= STDB_FL_DELAY;
                        end
                    end
                end
                STDB_FL_DELAY:
                begin
                    if (us_tick && (us_cnt_q + 1'b1 == flash_delay_q))
                    begin
                        fl_state_q <= STDB_FL_PULSE;
                        flash_q    <= 1'b1;
                        us_cnt_q   <= '0;
                    end
                end
                STDB_FL_PULSE:
                begin
                    if (flash_pulse_length_q == '0)
                    begin
                        if (!exposure_active)
                        begin
                            fl_state_q <= STDB_FL_IDLE;
                            flash_q    <= 1'b0;
                        end
                    end
                    else if (us_tick && (us_cnt_q + 1'b1 == flash_pulse_length_q))
                    begin
                        fl_state_q <= STDB_FL_IDLE;
                        flash_q    <= 1'b0;
                    end
                end
                default:
                begin
                    fl_state_q <= STDB_FL_IDLE;
                    flash_q    <= 1'b0;
                end
            endcase
        end
    end

    // One strobe drives every enabled output line at once
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_out_q <= '0;
            line_oe_q  <= '0;
        end
        else
        begin
            for (int i = 0; i < STDB_LINES; i++)
            begin
                line_oe_q[i]  <= line_bit(line_ctrl_q, i, STDB_CTL_DIR) == STDB_DIR_OUTPUT;
                line_out_q[i] <= (flash_q && line_bit(line_ctrl_q, i, STDB_CTL_FLASH_ON))
                                 ^ line_bit(line_ctrl_q, i, STDB_CTL_FLIP);
            end
        end
    end

    assign line_out = line_out_q;
    assign line_oe  = line_oe_q;

endmodule

// file: test/stdb_props.sv
`timescale 1ns/1ps
module stdb_props
    import stdb_pkg::*;
(
    // Clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // Sensor timing and lines
    input wire logic        exposure_start,
    input wire logic        exposure_active,
    input wire logic        trigger_mode_ext,
    input wire logic [3:0]  trig_fire,
    input wire logic [3:0]  line_in,
    input wire logic [3:0]  line_out,
    input wire logic [3:0]  line_oe
);
    logic [31:0] rf_q [5];
    logic        wp_q;
    logic [2:0]  wa_q;
    logic [3:0]  dirs;
    logic [3:0]  flip;
    logic [3:0]  fl;
    logic [3:0]  on;
    logic [3:0]  sv;
    logic        lvl;
    logic        lvl_q;
    logic [7:0]  run_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Shadow of the five writable registers below STATUS, stored at the data phase edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wp_q <= 1'b0;
            wa_q <= 3'h0;
            rf_q <= '{32'h0, 32'h0, 32'h0, 32'h0, 32'hffff_ffff};
        end
        else
        begin
            wp_q <= hready && hsel && htrans[1] && hwrite && haddr[7:0] < 8'h14;
            wa_q <= haddr[4:2];
            if (wp_q && hready)
                rf_q[wa_q] <= hwdata;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            dirs[i] = rf_q[0][8*i+STDB_CTL_DIR];
            flip[i] = rf_q[0][8*i+STDB_CTL_FLIP];
            fl[i]   = rf_q[0][8*i+STDB_CTL_FLASH_ON];
        end
    end
    assign on  = fl & dirs;
    assign sv  = (line_out ^ flip) & on;
    assign lvl = line_in[0] ^ flip[0];

    // Length of the latest high run on line 0, kept after it ends
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lvl_q <= 1'b0;
            run_q <= 8'h00;
        end
        else
        begin
            lvl_q <= lvl;
            if (lvl)
                run_q <= lvl_q ? run_q + 8'(run_q != 8'hff) : 8'h01;
        end
    end

    AST_OE_DIR: assert property ($stable(dirs) |-> line_oe == dirs)
        else $error("line_oe does not follow direction");
    AST_TRIG_OUT: assert property ((trig_fire & line_oe & $past(line_oe)) == 4'h0)
        else $error("trigger fired on an output line");
    AST_TRIG_ONE: assert property (trig_fire != 4'h0 |=> (trig_fire & $past(trig_fire)) == 4'h0)
        else $error("trigger pulse longer than one cycle");
    AST_TRIG_MIN: assert property (trig_fire[0] |-> run_q >= 8'h10)
        else $error("trigger accepted from a short pulse");
    AST_LINES_TOGETHER: assert property ($stable(rf_q[0]) |-> sv == 4'h0 || sv == on)
        else $error("strobe lines differ");
    AST_FLIP_IDLE: assert property ($stable(rf_q[0]) |-> ((line_out ^ flip) & ~fl) == 4'h0)
        else $error("idle line level ignores polarity");
    AST_FREE_RUN: assert property (!trigger_mode_ext && exposure_start && !$past(exposure_start)
        && rf_q[1] == 0 && rf_q[2] != 0 && rf_q[3] <= 1 && rf_q[4] == 32'hffff_ffff
        && sv == 4'h0 |-> ##2 sv == on)
        else $error("no strobe at exposure start");
    AST_ZERO_LEN: assert property (rf_q[2] == 0 && $fell(exposure_active) && sv != 4'h0
        |-> ##[1:3] sv == 4'h0)
        else $error("zero length strobe outlives exposure");

    cover property (trig_fire != 4'h0);
    cover property (sv != 4'h0);
    cover property (hsel && htrans[1] && !hwrite);
endmodule

bind stdb_strobe_debounce stdb_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .exposure_start(exposure_start), .exposure_active(exposure_active),
    .trigger_mode_ext(trigger_mode_ext), .trig_fire(trig_fire), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe));

// file: test/stdb_lights.sv
`timescale 1ns/1ps
module stdb_lights
(
    // Clock
    input  wire logic       hclk,
    // Pins
    input  wire logic [3:0] line_out,
    input  wire logic [3:0] line_oe,
    output logic      [3:0] line_in
);
    logic [3:0] src_q = 4'h0;

    // A driven pin shows the camera's level, else the trigger source owns it
    assign line_in = (line_oe & line_out) | (~line_oe & src_q);

    task automatic pulse(input int l, input int w);
        @(posedge hclk);
        src_q[l] <= 1'b1;
        repeat (w) @(posedge hclk);
        src_q[l] <= 1'b0;
    endtask
endmodule

// file: test/stdb_strobe_debounce_tb.sv
`timescale 1ns/1ps
module stdb_strobe_debounce_tb;
    import stdb_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        exposure_start;
    logic        exposure_active;
    logic        trigger_mode_ext;
    logic [3:0]  trig_fire;
    logic [3:0]  line_in;
    logic [3:0]  line_out;
    logic [3:0]  line_oe;
    logic [31:0] expq [$];
    logic [36:0] pat [3] = '{{5'h02, 32'h1}, {5'h06, 32'h38}, {5'h08, 32'ha2}};
    int          failures = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          ev = 0;
    int          rise = 0;
    int          st = 0;
    int          d;
    logic        son = 1'b0;
    logic        rdp = 1'b0;
    logic        lin0 = 1'b0;

    stdb_strobe_debounce dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .exposure_start(exposure_start), .exposure_active(exposure_active),
        .trigger_mode_ext(trigger_mode_ext), .trig_fire(trig_fire), .line_in(line_in),
        .line_out(line_out), .line_oe(line_oe));
    stdb_lights lit (.hclk(hclk), .line_out(line_out), .line_oe(line_oe), .line_in(line_in));

    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= dat;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Exposure of n+1 cycles, then room for the strobe to finish
    task automatic expo(input int n);
        @(posedge hclk);
        exposure_start  <= 1'b1;
        exposure_active <= 1'b1;
        @(posedge hclk);
        exposure_start <= 1'b0;
        repeat (n) @(posedge hclk);
        exposure_active <= 1'b0;
        repeat (600) @(posedge hclk);
    endtask

    task automatic chk(input logic [31:0] got);
        logic [31:0] e;
        comparisons++;
        e = (expq.size() > 0) ? expq.pop_front() : 32'hdead_0000;
        if (got !== e)
        begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic conclude();
        failures += expq.size();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Results: read data, {latency, trig_fire}, {start offset, strobe width}
    always @(posedge hclk)
    begin
        cyc++;
        if (rdp)
            chk(hrdata);
        if (rdp && hresp !== 1'b0)
        begin
            failures++;
            $display("[ERR] t=%0t hresp=%h exp=%h", $time, hresp, 1'b0);
        end
        rdp = hsel && htrans[1] && !hwrite && hreadyout;
        if ((!trigger_mode_ext && exposure_start) || (trigger_mode_ext && trig_fire != 4'h0))
            ev = cyc;
        if (line_in[0] && !lin0)
            rise = cyc;
        lin0 = line_in[0];
        if (trig_fire != 4'h0)
            chk({16'(cyc - rise), 12'h0, trig_fire});
        if (!son && (line_out & 4'hc) != 4'h0)
        begin
            son = 1'b1;
            st  = cyc;
        end
        if (son && (line_out & 4'hc) == 4'h0)
        begin
            son = 1'b0;
            chk({16'(st - ev), 16'(cyc - st)});
        end
    end

    initial
    begin
        repeat (30000) @(posedge hclk);
        failures++;
        conclude();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwdata = 32'h0;
        exposure_start = 1'b0;
        exposure_active = 1'b0;
        trigger_mode_ext = 1'b0;
        void'($urandom(68));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(STDB_OFS_PAT_MASK, 32'hffff_ffff);
        rd(STDB_OFS_PAT_PERIOD, 32'h0);
        rd(8'h18, 32'h0);
        bus(1'b1, STDB_OFS_LINE_CTRL, 32'h0505_0300);
        bus(1'b1, STDB_OFS_FLASH_LEN, 32'h1);
        rd(STDB_OFS_LINE_CTRL, 32'h0505_0300);
        rd(STDB_OFS_STATUS, 32'h0000_0200);
        for (int i = 0; i < 2; i++)
        begin
            d = i * ($urandom % 3 + 1);
            bus(1'b1, STDB_OFS_FLASH_DELAY, 32'(d));
            expq.push_back({16'(2 + d * 125), 16'h007d});
            expo(20);
        end
        bus(1'b1, STDB_OFS_FLASH_DELAY, 32'h0);
        bus(1'b1, STDB_OFS_FLASH_LEN, 32'h0);
        expq.push_back({16'h0002, 16'h0033});
        expo(50);
        bus(1'b1, STDB_OFS_FLASH_LEN, 32'h1);
        foreach (pat[k])
        begin
            bus(1'b1, STDB_OFS_PAT_MASK, pat[k][31:0]);
            bus(1'b1, STDB_OFS_PAT_PERIOD, {27'h0, pat[k][36:32]});
            for (int f = 0; f < pat[k][36:32]; f++)
            begin
                if (pat[k][f])
                    expq.push_back({16'h0002, 16'h007d});
                expo(20);
            end
        end
        bus(1'b1, STDB_OFS_PAT_PERIOD, 32'h0);
        bus(1'b1, STDB_OFS_PAT_MASK, 32'hffff_ffff);
        for (int m = 0; m < 2; m++)
        begin
            trigger_mode_ext <= m[0];
            lit.pulse(0, 15);
            repeat (40) @(posedge hclk);
            expq.push_back({16'h0012, 16'h0001});
            if (m == 1)
                expq.push_back({16'h0002, 16'h007d});
            lit.pulse(0, 16);
            repeat (300) @(posedge hclk);
        end
        trigger_mode_ext <= 1'b0;
        bus(1'b1, STDB_OFS_LINE_CTRL, 32'h0505_0308);
        bus(1'b1, STDB_OFS_FILTER_BASE, 32'h1);
        rd(STDB_OFS_FILTER_BASE, 32'h1);
        lit.pulse(0, 124);
        repeat (40) @(posedge hclk);
        expq.push_back({16'h007f, 16'h0001});
        lit.pulse(0, 125);
        repeat (300) @(posedge hclk);
        lit.pulse(2, 20);
        repeat (50) @(posedge hclk);
        conclude();
    end
endmodule
